/* logic/relay_defines.vh */
// relay_defines.vh: constants for the rf/wire relay timing block
// assumes a 125 MHz core clock; included by bare name
`ifndef RELAY_DEFINES_VH
`define RELAY_DEFINES_VH
`define CLK_PERIOD_NS        8
`define SHDLC_LIMIT_US       500
`define DELAY_BASE_US        210
`define DELAY_PER_BYTE_US    15
`define GUARD_LIMIT_US       190
`define POLL_ANSWER_US       1150
// the same budgets in 8 ns clock cycles
`define SHDLC_LIMIT_CYC      20'h0f424
`define DELAY_BASE_CYC       20'h0668a
`define DELAY_PER_BYTE_CYC   20'h00753
`define GUARD_LIMIT_CYC      20'h05cc6
`define POLL_ANSWER_CYC      20'h23186
`define US_CYCLES(us)        (((us) * 1000) / `CLK_PERIOD_NS)
`define CNT_W                20
`define LEN_W                8
`define MAX_FIELD_LEN        8'h1e
`define REQ_LEN              8'h01
`define ZERO_CNT             20'h00000
// card state codes
`define CARD_IDLE            2'h0
`define CARD_HALT            2'h1
`define CARD_ACTIVE          2'h2
`define CARD_ACTIVE_H        2'h3
// relay modes
`define MODE_SHDLC           2'h0
`define MODE_CLT_A           2'h1
`define MODE_CLT_F           2'h2
`endif

/* logic/edge_sync.v */
// edge_sync.v: two-stage synchroniser with rise and fall pulses
// assumes the input is asynchronous to clock
`default_nettype none
module edge_sync (
   // clock and reset
   input  wire clock,
   input  wire nrst,
   // async level in
   input  wire din,
   // synchronised outputs
   output reg  level,
   output reg  rise,
   output reg  fall
);
   reg meta_r;
   reg sync_r;
   always @(posedge clock) begin
      if (!nrst) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         level  <= 1'b0;
         rise   <= 1'b0;
         fall   <= 1'b0;
      end else begin
         meta_r <= din;
         sync_r <= meta_r;
         level  <= sync_r;
         rise   <= sync_r & ~level;
         fall   <= ~sync_r & level;
      end
   end
endmodule // edge_sync
`default_nettype wire

/* logic/budget_timer.v */
// budget_timer.v: latency counter with limit compare
// assumes start and stop are single-cycle pulses on clock
`default_nettype none
`include "relay_defines.vh"
module budget_timer (
   // clock and reset
   input  wire                clock,
   input  wire                nrst,
   // control
   input  wire                start,
   input  wire                stop,
   input  wire [`CNT_W-1:0]   limit,
   // status
   output reg  [`CNT_W-1:0]   count_r,
   output reg                 running_r,
   output reg                 over_r
);
   always @(posedge clock) begin
      if (!nrst) begin
         count_r   <= `ZERO_CNT;
         running_r <= 1'b0;
         over_r    <= 1'b0;
      end else if (start) begin
         count_r   <= `ZERO_CNT;
         running_r <= 1'b1;
         over_r    <= 1'b0;
      end else if (running_r) begin
         if (stop)
            running_r <= 1'b0;
         else
            count_r <= count_r + 1'b1;
         if (count_r >= limit)
            over_r <= 1'b1;
      end
   end
endmodule // budget_timer
`default_nettype wire

/* logic/clf_relay.v */
// clf_relay.v: relay sequencing and latency tracking between rf and wire
// assumes rf framer and swp framer give byte strobes on clock; s1/s2 are pins
`default_nettype none
`include "relay_defines.vh"
module clf_relay (
   // clock and reset
   input  wire               clock,
   input  wire               nrst,
   // configuration
   input  wire [1:0]         mode,
   input  wire               pipeline_en,
   // rf receive side
   input  wire               rf_rx_byte,
   input  wire               rf_rx_end,
   input  wire               rf_rx_req,
   input  wire               rf_rx_err,
   // swp pins sampled
   input  wire               s1_eof_pin,
   input  wire               s2_sof_pin,
   // swp receive from card
   input  wire               wire_rx_byte,
   input  wire               wire_rx_end,
   input  wire               wire_rx_crc_ok,
   input  wire               wire_goto_init,
   input  wire               wire_goto_halt,
   // rf transmit side
   input  wire               rf_tx_edge,
   input  wire               rf_tx_byte,
   // card entry branch
   input  wire               sel_from_halt,
   input  wire               card_select,
   // frame build commands
   output reg                wire_tx_start,
   output reg                wire_tx_commit,
   output reg                wire_tx_corrupt,
   output reg  [`LEN_W-1:0]  wire_tx_len,
   output reg                rf_tx_start,
   output reg                rf_tx_abort,
   // state and status
   output reg  [1:0]         card_state,
   output reg                ready_next,
   output reg  [`CNT_W-1:0]  rf_to_wire_delay,
   output reg  [`CNT_W-1:0]  wire_to_rf_delay,
   output reg  [`CNT_W-1:0]  total_relay_delay,
   output reg                budget_over
);
   localparam [`CNT_W-1:0] SHDLC_CYC  = `SHDLC_LIMIT_CYC;
   localparam [`CNT_W-1:0] BASE_CYC   = `DELAY_BASE_CYC;
   localparam [`CNT_W-1:0] BYTE_CYC   = `DELAY_PER_BYTE_CYC;
   localparam [`CNT_W-1:0] GUARD_CYC  = `GUARD_LIMIT_CYC;
   localparam [`CNT_W-1:0] POLL_CYC   = `POLL_ANSWER_CYC;
   // relay phases
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_RX   = 3'h1;
   localparam [2:0] ST_SEND = 3'h2;
   localparam [2:0] ST_WAIT = 3'h3;
   localparam [2:0] ST_TX   = 3'h4;

   function [`CNT_W-1:0] byte_budget;
      input [`LEN_W-1:0] n;
      byte_budget = BYTE_CYC * {{(`CNT_W-`LEN_W){1'b0}}, n};
   endfunction

   wire s1_rise;
   wire s2_rise;
   edge_sync u_s1 (
      .clock (clock),
      .nrst  (nrst),
      .din   (s1_eof_pin),
      .level (),
      .rise  (s1_rise),
      .fall  ()
   );
   edge_sync u_s2 (
      .clock (clock),
      .nrst  (nrst),
      .din   (s2_sof_pin),
      .level (),
      .rise  (s2_rise),
      .fall  ()
   );

   reg  [2:0]        state_r;
   reg  [2:0]        state_nxt;
   reg  [`LEN_W-1:0] rx_cnt_r;
   reg  [`LEN_W-1:0] tx_cnt_r;
   reg               is_req_r;
   reg               oversize_r;
   reg               sent_r;
   reg               rf_started_r;
   reg               wire_started_r;
   wire              sof_evt = s2_rise & (state_r == ST_WAIT);
   wire [`CNT_W-1:0] up_count;
   wire [`CNT_W-1:0] dn_count;
   wire              up_run;
   wire              dn_run;
   wire              up_over;
   wire              dn_over;
   reg  [`CNT_W-1:0] up_limit;
   reg  [`CNT_W-1:0] dn_limit;

   budget_timer u_up (
      .clock     (clock),
      .nrst      (nrst),
      .start     (rf_rx_end & (state_r == ST_RX)),
      .stop      (s1_rise),
      .limit     (up_limit),
      .count_r   (up_count),
      .running_r (up_run),
      .over_r    (up_over)
   );
   budget_timer u_dn (
      .clock     (clock),
      .nrst      (nrst),
      .start     (sof_evt),
      .stop      (rf_tx_edge | ready_next),
      .limit     (dn_limit),
      .count_r   (dn_count),
      .running_r (dn_run),
      .over_r    (dn_over)
   );

   always @* begin
      if (mode == `MODE_SHDLC) begin
         up_limit = SHDLC_CYC;
         dn_limit = SHDLC_CYC;
      end else if (mode == `MODE_CLT_F) begin
         up_limit = BASE_CYC + byte_budget(rx_cnt_r);
         dn_limit = POLL_CYC;
      end else if (is_req_r) begin
         up_limit = GUARD_CYC;
         dn_limit = GUARD_CYC;
      end else begin
         up_limit = BASE_CYC + byte_budget(rx_cnt_r);
         // remainder of the shared budget
         dn_limit = BASE_CYC + byte_budget(rx_cnt_r) + byte_budget(tx_cnt_r) - rf_to_wire_delay;
      end
   end

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (rf_rx_byte | rf_rx_req)
               state_nxt = ST_RX;
         end
         ST_RX: begin
            if (rf_rx_err)
               state_nxt = ST_IDLE;
            else if (rf_rx_end)
               state_nxt = ST_SEND;
         end
         ST_SEND: begin
            if (s1_rise)
               state_nxt = ST_WAIT;
         end
         ST_WAIT: begin
            if (wire_rx_end & ~wire_rx_crc_ok)
               state_nxt = ST_IDLE;
            else if (wire_rx_end & (tx_cnt_r == 8'h00))
               state_nxt = ST_IDLE;
            else if (wire_rx_end)
               state_nxt = ST_TX;
         end
         ST_TX: begin
            if (rf_tx_byte & (tx_cnt_r == 8'h01))
               state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always @(posedge clock) begin
      if (!nrst) begin
         state_r          <= ST_IDLE;
         rx_cnt_r         <= 8'h00;
         tx_cnt_r         <= 8'h00;
         is_req_r         <= 1'b0;
         oversize_r       <= 1'b0;
         sent_r           <= 1'b0;
         rf_started_r     <= 1'b0;
         wire_started_r   <= 1'b0;
         wire_tx_start    <= 1'b0;
         wire_tx_commit   <= 1'b0;
         wire_tx_corrupt  <= 1'b0;
         wire_tx_len      <= 8'h00;
         rf_tx_start      <= 1'b0;
         rf_tx_abort      <= 1'b0;
         card_state       <= `CARD_IDLE;
         ready_next       <= 1'b1;
         rf_to_wire_delay <= `ZERO_CNT;
         wire_to_rf_delay <= `ZERO_CNT;
         total_relay_delay <= `ZERO_CNT;
         budget_over      <= 1'b0;
      end else begin
         state_r         <= state_nxt;
         wire_tx_start   <= 1'b0;
         wire_tx_commit  <= 1'b0;
         rf_tx_start     <= 1'b0;
         rf_tx_abort     <= 1'b0;
         ready_next      <= (state_nxt == ST_IDLE);
         if (state_r == ST_IDLE) begin
            rx_cnt_r       <= 8'h00;
            tx_cnt_r       <= 8'h00;
            oversize_r     <= 1'b0;
            sent_r         <= 1'b0;
            rf_started_r   <= 1'b0;
            wire_started_r <= 1'b0;
            is_req_r       <= rf_rx_req;
         end
         // first byte of a block, count from a clean base
         if (rf_rx_byte & (state_r == ST_IDLE))
            rx_cnt_r <= 8'h01;
         else if (rf_rx_byte & (state_r == ST_RX)) begin
            if (rx_cnt_r == `MAX_FIELD_LEN)
               oversize_r <= 1'b1;
            else
               rx_cnt_r <= rx_cnt_r + 8'h01;
         end
         if (pipeline_en & (state_r == ST_RX) & ~wire_started_r & rf_rx_byte) begin
            wire_tx_start  <= 1'b1;
            wire_started_r <= 1'b1;
         end
         if ((state_r == ST_RX) & rf_rx_end) begin
            wire_tx_commit  <= 1'b1;
            wire_tx_start   <= ~wire_started_r;
            wire_started_r  <= 1'b1;
            if (is_req_r)
               wire_tx_len <= `REQ_LEN;
            else if (oversize_r)
               wire_tx_len <= 8'h00;
            else
               wire_tx_len <= rx_cnt_r;
            wire_tx_corrupt <= oversize_r & wire_started_r;
            if (is_req_r & (card_state == `CARD_ACTIVE))
               card_state <= `CARD_IDLE;
            else if (is_req_r & (card_state == `CARD_ACTIVE_H))
               card_state <= `CARD_HALT;
         end
         if ((state_r == ST_WAIT) & wire_rx_byte)
            tx_cnt_r <= tx_cnt_r + 8'h01;
         if ((state_r == ST_WAIT) & pipeline_en & wire_rx_byte & ~rf_started_r) begin
            rf_tx_start  <= 1'b1;
            rf_started_r <= 1'b1;
         end
         if ((state_r == ST_WAIT) & wire_rx_end) begin
            if (~wire_rx_crc_ok)
               rf_tx_abort <= rf_started_r;
            else if (~rf_started_r & (tx_cnt_r != 8'h00)) begin
               rf_tx_start  <= 1'b1;
               rf_started_r <= 1'b1;
            end
         end
         if ((state_r == ST_TX) & rf_tx_byte)
            tx_cnt_r <= tx_cnt_r - 8'h01;
         if (wire_goto_halt)
            card_state <= `CARD_HALT;
         else if (wire_goto_init)
            card_state <= sel_from_halt ? `CARD_HALT : `CARD_IDLE;
         else if (card_select)
            card_state <= sel_from_halt ? `CARD_ACTIVE_H : `CARD_ACTIVE;
         if (s1_rise & up_run)
            rf_to_wire_delay <= up_count;
         if ((rf_tx_edge | ready_next) & dn_run)
            wire_to_rf_delay <= dn_count;
         total_relay_delay <= rf_to_wire_delay + wire_to_rf_delay;
         budget_over <= up_over | dn_over;
      end
   end
endmodule // clf_relay
`default_nettype wire

/* testbench/relay_chk.sv */
// relay_chk.sv: port assertions for the rf/wire relay block
// assumes a bind onto clf_relay with one clock domain
`default_nettype none
`include "relay_defines.vh"
module relay_chk (
   // watched ports
   input wire logic              clock,
   input wire logic              nrst,
   input wire logic [1:0]        mode,
   input wire logic              pipeline_en,
   input wire logic              rf_rx_end,
   input wire logic              rf_rx_req,
   input wire logic              wire_rx_end,
   input wire logic              wire_rx_crc_ok,
   input wire logic              wire_goto_init,
   input wire logic              wire_goto_halt,
   input wire logic              sel_from_halt,
   input wire logic              wire_tx_commit,
   input wire logic [`LEN_W-1:0] wire_tx_len,
   input wire logic              rf_tx_start,
   input wire logic [1:0]        card_state,
   input wire logic              ready_next
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   a_reset_vals: assert property ($rose(nrst) |-> ready_next && card_state == `CARD_IDLE)
      else $error("state after reset wrong");
   a_commit_next: assert property (rf_rx_end && mode == `MODE_CLT_A |=> wire_tx_commit)
      else $error("no frame after rf block");
   a_len_cap: assert property (wire_tx_commit |-> wire_tx_len <= `MAX_FIELD_LEN)
      else $error("frame length above cap");
   a_req_one: assert property (rf_rx_req && card_state == `CARD_IDLE
      && mode == `MODE_CLT_A ##1 rf_rx_end |=> wire_tx_commit && wire_tx_len == `REQ_LEN)
      else $error("request frame length wrong");
   a_bad_crc: assert property (wire_rx_end && !wire_rx_crc_ok && !pipeline_en
      |=> !rf_tx_start [*4])
      else $error("rf started on bad crc");
   a_rf_start: assert property (wire_rx_end && wire_rx_crc_ok && mode == `MODE_CLT_A
      && !wire_goto_init && !wire_goto_halt |=> rf_tx_start)
      else $error("rf not started after frame");
   a_goto_halt: assert property (wire_goto_halt |-> ##[1:2] card_state == `CARD_HALT)
      else $error("halt order not taken");
   a_goto_init: assert property (wire_goto_init |->
      ##[1:2] card_state == (sel_from_halt ? `CARD_HALT : `CARD_IDLE))
      else $error("init order wrong branch");
   a_req_active: assert property (rf_rx_req && card_state[1] |-> ##[1:4] !card_state[1])
      else $error("request left card active");
endmodule // relay_chk
`default_nettype wire

/* testbench/uicc_model.sv */
// uicc_model.sv: card side of the single wire link at frame level
// assumes the bench calls one task at a time
`default_nettype none
module uicc_model (
   // clock
   input  wire logic clock,
   // line pins and card frame strobes
   output var  logic s1_eof_pin,
   output var  logic s2_sof_pin,
   output var  logic wire_rx_byte,
   output var  logic wire_rx_end,
   output var  logic wire_rx_crc_ok,
   output var  logic wire_goto_init,
   output var  logic wire_goto_halt
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int BIT_CYC = 20;
   initial {s1_eof_pin, s2_sof_pin, wire_rx_byte, wire_rx_end} = 4'h0;
   initial {wire_rx_crc_ok, wire_goto_init, wire_goto_halt} = 3'h0;
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic eof(input int gap);
      tick(gap);
      s1_eof_pin = 1'b1;
      tick(BIT_CYC);
      s1_eof_pin = 1'b0;
   endtask
   task automatic answer(input int n, input logic crc, input int kind);
      tick(1);
      s2_sof_pin = 1'b1;
      repeat (n) begin
         tick(BIT_CYC);
         wire_rx_byte = 1'b1;
         tick(1);
         wire_rx_byte = 1'b0;
      end
      tick(BIT_CYC);
      wire_rx_end = 1'b1;
      wire_rx_crc_ok = crc;
      wire_goto_init = (kind == 1);
      wire_goto_halt = (kind == 2);
      tick(1);
      {s2_sof_pin, wire_rx_end, wire_rx_crc_ok, wire_goto_init, wire_goto_halt} = 5'h00;
   endtask
endmodule // uicc_model
`default_nettype wire

/* testbench/tb.sv */
// tb.sv: self-checking bench for the relay timing block
// assumes clf_relay, relay_chk and uicc_model compiled first
`default_nettype none
`include "relay_defines.vh"
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic              clock = 1'b0;
   logic              nrst = 1'b0;
   logic [1:0]        mode = `MODE_CLT_A;
   logic              pipeline_en = 1'b0;
   logic              rf_rx_byte = 1'b0, rf_rx_end = 1'b0, rf_rx_req = 1'b0;
   logic              rf_tx_edge = 1'b0, sel_from_halt = 1'b0, card_select = 1'b0;
   logic              rf_tx_byte = 1'b0, rf_rx_err = 1'b0, ab_hit = 1'b0;
   logic              s1_eof_pin, s2_sof_pin, wire_rx_byte, wire_rx_end, wire_rx_crc_ok;
   logic              wire_goto_init, wire_goto_halt, wire_tx_start, wire_tx_commit;
   logic              wire_tx_corrupt, rf_tx_start, rf_tx_abort, ready_next, budget_over;
   logic [`LEN_W-1:0] wire_tx_len;
   logic [1:0]        card_state;
   logic [`CNT_W-1:0] rf_to_wire_delay, wire_to_rf_delay, total_relay_delay;
   int                miscompares = 0;
   int                samples_checked = 0;
   always #4 clock = ~clock;
   clf_relay clf_relay_i (.clock, .nrst, .mode, .pipeline_en, .rf_rx_byte, .rf_rx_end,
      .rf_rx_req, .rf_rx_err, .s1_eof_pin, .s2_sof_pin, .wire_rx_byte, .wire_rx_end,
      .wire_rx_crc_ok, .wire_goto_init, .wire_goto_halt, .rf_tx_edge, .rf_tx_byte,
      .sel_from_halt, .card_select, .wire_tx_start, .wire_tx_commit, .wire_tx_corrupt,
      .wire_tx_len, .rf_tx_start, .rf_tx_abort, .card_state, .ready_next, .rf_to_wire_delay,
      .wire_to_rf_delay, .total_relay_delay, .budget_over);
   uicc_model uicc_model_i (.clock, .s1_eof_pin, .s2_sof_pin, .wire_rx_byte, .wire_rx_end,
      .wire_rx_crc_ok, .wire_goto_init, .wire_goto_halt);
   task automatic chk(input string nm, input logic [`CNT_W-1:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic rf_block(input int n, input logic req);
      for (int i = 0; i < n; i++) begin
         rf_rx_byte = 1'b1;
         rf_rx_req = req && (i == 0);
         tick(1);
      end
      {rf_rx_byte, rf_rx_req, rf_rx_end} = 3'h1;
      tick(1);
      rf_rx_end = 1'b0;
   endtask
   task automatic idle_wait();
      for (int i = 0; i < 400 && ready_next !== 1'b1; i++) tick(1);
      chk("ready_next", ready_next, 1'b1);
   endtask
   // card answers while rf starts are watched
   task automatic card_answer(input int n, input logic crc, input int kind, output logic hit);
      hit = 1'b0;
      ab_hit = 1'b0;
      fork
         uicc_model_i.answer(n, crc, kind);
         repeat (n * 21 + 30) begin
            tick(1);
            if (rf_tx_start === 1'b1) hit = 1'b1;
            if (rf_tx_abort === 1'b1) ab_hit = 1'b1;
         end
      join
   endtask
   // first modulation edge, then one strobe per sent byte
   task automatic rf_send(input int n);
      rf_tx_edge = 1'b1;
      tick(1);
      {rf_tx_edge, rf_tx_byte} = 2'h1;
      tick(n);
      rf_tx_byte = 1'b0;
   endtask
   task automatic t_relay(input logic [1:0] md, input int n, input int gap);
      logic hit;
      mode = md;
      rf_block(n, 1'b0);
      if (md == `MODE_CLT_A) begin
         chk("wire_tx_commit", wire_tx_commit, 1'b1);
         chk("wire_tx_len", wire_tx_len, n);
         chk("wire_tx_start", wire_tx_start, 1'b1);
      end
      uicc_model_i.eof(gap);
      chk("up delay", rf_to_wire_delay >= gap && rf_to_wire_delay <= gap + 12, 1'b1);
      chk("budget_over", budget_over, 1'b0);
      card_answer(2, 1'b1, 0, hit);
      chk("rf_tx_start", hit, 1'b1);
      rf_send(2);
      chk("down delay", wire_to_rf_delay >= 40 && wire_to_rf_delay <= 80, 1'b1);
      chk("total", total_relay_delay, rf_to_wire_delay + wire_to_rf_delay);
      if (md == `MODE_SHDLC) chk("budget_over", budget_over, 1'b0);
      else chk("budget_over", budget_over, 1'b0);
      idle_wait();
   endtask
   task automatic t_fault(input int n, input logic crc, input logic pipe);
      logic hit;
      pipeline_en = pipe;
      rf_block(n, 1'b0);
      if (n > `MAX_FIELD_LEN) chk("wire_tx_len", wire_tx_len, 8'h00);
      chk("wire_tx_corrupt", wire_tx_corrupt, pipe && n > `MAX_FIELD_LEN);
      chk("wire_tx_start", wire_tx_start, !pipe);
      uicc_model_i.eof(10);
      card_answer(2, crc, 0, hit);
      chk("rf_tx_start", hit, crc | pipe);
      chk("rf_tx_abort", ab_hit, pipe & ~crc);
      if (crc) rf_send(2);
      idle_wait();
   endtask
   task automatic t_rf_err();
      rf_rx_byte = 1'b1;
      tick(1);
      {rf_rx_byte, rf_rx_err} = 2'h1;
      tick(1);
      rf_rx_err = 1'b0;
      chk("wire_tx_commit", wire_tx_commit, 1'b0);
      idle_wait();
   endtask
   task automatic t_request(input int gap, input logic late);
      logic hit;
      rf_block(1, 1'b1);
      chk("wire_tx_len", wire_tx_len, `REQ_LEN);
      uicc_model_i.eof(gap);
      chk("budget_over", budget_over, late);
      card_answer(0, 1'b1, 1, hit);
      tick(2);
      chk("card_state", card_state, `CARD_IDLE);
      idle_wait();
   endtask
   task automatic select(input logic from_halt);
      sel_from_halt = from_halt;
      card_select = 1'b1;
      tick(1);
      card_select = 1'b0;
      tick(1);
      chk("card_state", card_state, from_halt ? `CARD_ACTIVE_H : `CARD_ACTIVE);
   endtask
   task automatic t_req_active(input logic from_halt);
      logic hit;
      select(from_halt);
      rf_block(1, 1'b1);
      chk("card_state", card_state, from_halt ? `CARD_HALT : `CARD_IDLE);
      uicc_model_i.eof(10);
      card_answer(0, 1'b1, 1, hit);
      chk("rf_tx_start", hit, 1'b0);
      idle_wait();
   endtask
   task automatic t_goto(input logic from_halt);
      logic hit;
      select(from_halt);
      card_answer(0, 1'b1, 1, hit);
      chk("card_state", card_state, from_halt ? `CARD_HALT : `CARD_IDLE);
      select(from_halt);
      card_answer(0, 1'b1, 2, hit);
      chk("card_state", card_state, `CARD_HALT);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      tick(4);
      nrst = 1'b1;
      tick(1);
      chk("ready_next", ready_next, 1'b1);
      chk("card_state", card_state, `CARD_IDLE);
      t_relay(`MODE_SHDLC, 3, 100);
      t_relay(`MODE_CLT_F, 2, 20);
      t_relay(`MODE_CLT_A, 1, 20);
      t_relay(`MODE_CLT_A, `MAX_FIELD_LEN, 20);
      t_fault(`MAX_FIELD_LEN + 1, 1'b1, 1'b0);
      t_fault(`MAX_FIELD_LEN + 1, 1'b0, 1'b1);
      t_fault(2, 1'b0, 1'b0);
      t_rf_err();
      t_request(10, 1'b0);
      t_request(24000, 1'b1);
      t_req_active(1'b0);
      t_req_active(1'b1);
      t_goto(1'b0);
      t_goto(1'b1);
      complete_run();
   end
   initial begin
      #1000000;
      miscompares++;
      complete_run();
   end
endmodule // tb
bind clf_relay relay_chk relay_chk_i (.clock, .nrst, .mode, .pipeline_en, .rf_rx_end,
   .rf_rx_req, .wire_rx_end, .wire_rx_crc_ok, .wire_goto_init, .wire_goto_halt,
   .sel_from_halt, .wire_tx_commit, .wire_tx_len, .rf_tx_start, .card_state, .ready_next);
`default_nettype wire
